// *** ifeb_pkg.sv ***
// Constants, field layout and carrier types of the interrupt flag and enable bank
`default_nettype none
package ifeb_pkg;

  // Register indices in special purpose data memory
  localparam int unsigned REG_IDX_W = 3;
  localparam logic [2:0] IDX_EDGE  = 3'h0;
  localparam logic [2:0] IDX_CTRL0 = 3'h1;
  localparam logic [2:0] IDX_CTRL1 = 3'h2;
  localparam logic [2:0] IDX_CTRL2 = 3'h3;
  localparam logic [2:0] IDX_GRP0  = 3'h4;
  localparam logic [2:0] IDX_GRP1  = 3'h5;
  localparam logic [2:0] IDX_GRP2  = 3'h6;

  // Implemented bits; everything else reads zero and ignores writes
  localparam logic [7:0] MASK_EDGE  = 8'h0f;
  localparam logic [7:0] MASK_CTRL0 = 8'h7f;
  localparam logic [7:0] MASK_CTRL1 = 8'hff;
  localparam logic [7:0] MASK_CTRL2 = 8'hff;
  localparam logic [7:0] MASK_GRP0  = 8'h33;
  localparam logic [7:0] MASK_GRP1  = 8'hff;
  localparam logic [7:0] MASK_GRP2  = 8'h33;
  localparam logic [7:0] REG_RESET  = 8'h00;

  // Edge select fields
  localparam int unsigned FIRST_SEL_LSB  = 0;
  localparam int unsigned SECOND_SEL_LSB = 2;
  localparam int unsigned SEL_W          = 2;
  localparam int unsigned SEL_RISE       = 0;
  localparam int unsigned SEL_FALL       = 1;

  // Primary control bits, as positions in {ctrl2, ctrl1, ctrl0}
  localparam int unsigned C1_BASE = 8;
  localparam int unsigned C2_BASE = 16;
  localparam int unsigned C0_GLOBAL_EN = 0;
  localparam int unsigned C0_PIN0_EN   = 1;
  localparam int unsigned C0_CMP_EN    = 2;
  localparam int unsigned C0_GRP0_EN   = 3;
  localparam int unsigned C0_PIN0_F    = 4;
  localparam int unsigned C0_CMP_F     = 5;
  localparam int unsigned C0_GRP0_F    = 6;
  localparam int unsigned C1_GRP1_EN   = C1_BASE + 0;
  localparam int unsigned C1_GRP2_EN   = C1_BASE + 1;
  localparam int unsigned C1_ADC_EN    = C1_BASE + 2;
  localparam int unsigned C1_TB0_EN    = C1_BASE + 3;
  localparam int unsigned C1_GRP1_F    = C1_BASE + 4;
  localparam int unsigned C1_GRP2_F    = C1_BASE + 5;
  localparam int unsigned C1_ADC_F     = C1_BASE + 6;
  localparam int unsigned C1_TB0_F     = C1_BASE + 7;
  localparam int unsigned C2_TB1_EN    = C2_BASE + 0;
  localparam int unsigned C2_PIN1_EN   = C2_BASE + 1;
  localparam int unsigned C2_SIM_EN    = C2_BASE + 2;
  localparam int unsigned C2_UART_EN   = C2_BASE + 3;
  localparam int unsigned C2_TB1_F     = C2_BASE + 4;
  localparam int unsigned C2_PIN1_F    = C2_BASE + 5;
  localparam int unsigned C2_SIM_F     = C2_BASE + 6;
  localparam int unsigned C2_UART_F    = C2_BASE + 7;

  // Group register bits; each enable sits GRP_F2E below its flag
  localparam int unsigned GRP_F2E   = 4;
  localparam int unsigned G0_STA_F  = 5;
  localparam int unsigned G0_STP_F  = 4;
  localparam int unsigned G1_ST1A_F = 7;
  localparam int unsigned G1_ST1P_F = 6;
  localparam int unsigned G1_PTA_F  = 5;
  localparam int unsigned G1_PTP_F  = 4;
  localparam int unsigned G2_EE_F   = 5;
  localparam int unsigned G2_LV_F   = 4;

  // Source vector numbers, lowest number wins
  localparam int unsigned SRC_NUM = 11;
  localparam logic [3:0] VEC_PIN0 = 4'h0;
  localparam logic [3:0] VEC_CMP  = 4'h1;
  localparam logic [3:0] VEC_GRP0 = 4'h2;
  localparam logic [3:0] VEC_GRP1 = 4'h3;
  localparam logic [3:0] VEC_GRP2 = 4'h4;
  localparam logic [3:0] VEC_ADC  = 4'h5;
  localparam logic [3:0] VEC_TB0  = 4'h6;
  localparam logic [3:0] VEC_TB1  = 4'h7;
  localparam logic [3:0] VEC_PIN1 = 4'h8;
  localparam logic [3:0] VEC_SIM  = 4'h9;
  localparam logic [3:0] VEC_UART = 4'ha;

  localparam logic [SRC_NUM-1:0][4:0] SRC_FLAG_POS = {
    5'(C2_UART_F), 5'(C2_SIM_F), 5'(C2_PIN1_F), 5'(C2_TB1_F), 5'(C1_TB0_F), 5'(C1_ADC_F),
    5'(C1_GRP2_F), 5'(C1_GRP1_F), 5'(C0_GRP0_F), 5'(C0_CMP_F), 5'(C0_PIN0_F)};
  localparam logic [SRC_NUM-1:0][4:0] SRC_EN_POS = {
    5'(C2_UART_EN), 5'(C2_SIM_EN), 5'(C2_PIN1_EN), 5'(C2_TB1_EN), 5'(C1_TB0_EN),
    5'(C1_ADC_EN), 5'(C1_GRP2_EN), 5'(C1_GRP1_EN), 5'(C0_GRP0_EN), 5'(C0_CMP_EN),
    5'(C0_PIN0_EN)};

  // One-cycle event pulses from the internal sources
  typedef struct packed {
    logic comparator;
    logic converter;
    logic timebase0;
    logic timebase1;
    logic serial_module;
    logic async_serial;
    logic std_timer0_a;
    logic std_timer0_p;
    logic std_timer1_a;
    logic std_timer1_p;
    logic periodic_timer_a;
    logic periodic_timer_p;
    logic eeprom;
    logic low_voltage;
  } ifeb_evt_s;

  typedef struct packed {
    logic [7:0] edge_select;
    logic [7:0] primary_ctrl_2;
    logic [7:0] primary_ctrl_1;
    logic [7:0] primary_ctrl_0;
    logic [7:0] group_ctrl_0;
    logic [7:0] group_ctrl_1;
    logic [7:0] group_ctrl_2;
    logic [1:0] pin_prev;
    logic       primed;
    logic [7:0] rdata;
    logic       irq_req;
    logic [3:0] irq_vec;
  } ifeb_state_s;

endpackage
`default_nettype wire

// *** ifeb_bank.sv ***
// Interrupt request flag and enable register bank with vector selection
`default_nettype none
module ifeb_bank (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // CPU special register port
  input  wire logic [2:0]        sfr_sel,
  input  wire logic              sfr_wr,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata,
  // CPU servicing
  input  wire logic              stack_full,
  input  wire logic              irq_ack,
  output logic                   irq_req,
  output logic      [3:0]        irq_vector,
  // Event sources
  input  wire logic              first_ext_pin,
  input  wire logic              second_ext_pin,
  input  wire ifeb_pkg::ifeb_evt_s evt
);

  ifeb_pkg::ifeb_state_s s_reg;
  ifeb_pkg::ifeb_state_s s_next;
  logic [1:0]            pin_evt;
  logic [23:0]           prim_next;
  logic [23:0]           prim_set;
  logic [23:0]           prim_now;
  logic [7:0]            g0_set;
  logic [7:0]            g1_set;
  logic [7:0]            g2_set;
  logic [2:0]            grp_hit;
  logic [ifeb_pkg::SRC_NUM-1:0] pend;
  logic                  ack_take;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                    input logic now);
    edge_hit = (sel[ifeb_pkg::SEL_RISE] & ~prev & now) |
               (sel[ifeb_pkg::SEL_FALL] & prev & ~now);
  endfunction

  // Group fires only on a new member event whose enable is set, so a
  // still-set member flag cannot re-raise the group after servicing
  function automatic logic group_hit(input logic [7:0] gset, input logic [7:0] greg);
    group_hit = |(8'(gset >> ifeb_pkg::GRP_F2E) & greg);
  endfunction

  function automatic logic [3:0] first_pending(input logic [ifeb_pkg::SRC_NUM-1:0] p);
    first_pending = 4'h0;
    for (int i = ifeb_pkg::SRC_NUM - 1; i >= 0; i--) begin
      if (p[i]) begin
        first_pending = 4'(i);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin edge detect; the first cycle after reset only samples
  for (genvar i = 0; i < 2; i++) begin : g_pin
    localparam int unsigned LSB = (i == 0) ? ifeb_pkg::FIRST_SEL_LSB
                                           : ifeb_pkg::SECOND_SEL_LSB;
    logic now_lvl;
    assign now_lvl    = (i == 0) ? first_ext_pin : second_ext_pin;
    assign pin_evt[i] = s_reg.primed &
      edge_hit(s_reg.edge_select[LSB +: ifeb_pkg::SEL_W], s_reg.pin_prev[i], now_lvl);
  end

  assign ack_take = irq_ack & s_reg.irq_req;
  // Flat view of the primary registers for indexed checks
  assign prim_now = {s_reg.primary_ctrl_2, s_reg.primary_ctrl_1, s_reg.primary_ctrl_0};

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    s_next.pin_prev = {second_ext_pin, first_ext_pin};
    s_next.primed   = 1'b1;

    g0_set = 8'h00;
    g0_set[ifeb_pkg::G0_STA_F]  = evt.std_timer0_a;
    g0_set[ifeb_pkg::G0_STP_F]  = evt.std_timer0_p;
    g1_set = 8'h00;
    g1_set[ifeb_pkg::G1_ST1A_F] = evt.std_timer1_a;
    g1_set[ifeb_pkg::G1_ST1P_F] = evt.std_timer1_p;
    g1_set[ifeb_pkg::G1_PTA_F]  = evt.periodic_timer_a;
    g1_set[ifeb_pkg::G1_PTP_F]  = evt.periodic_timer_p;
    g2_set = 8'h00;
    g2_set[ifeb_pkg::G2_EE_F]   = evt.eeprom;
    g2_set[ifeb_pkg::G2_LV_F]   = evt.low_voltage;
    grp_hit = {group_hit(g2_set, s_reg.group_ctrl_2), group_hit(g1_set, s_reg.group_ctrl_1),
               group_hit(g0_set, s_reg.group_ctrl_0)};

    prim_set = 24'h000000;
    prim_set[ifeb_pkg::C0_PIN0_F] = pin_evt[0];
    prim_set[ifeb_pkg::C0_CMP_F]  = evt.comparator;
    prim_set[ifeb_pkg::C0_GRP0_F] = grp_hit[0];
    prim_set[ifeb_pkg::C1_GRP1_F] = grp_hit[1];
    prim_set[ifeb_pkg::C1_GRP2_F] = grp_hit[2];
    prim_set[ifeb_pkg::C1_ADC_F]  = evt.converter;
    prim_set[ifeb_pkg::C1_TB0_F]  = evt.timebase0;
    prim_set[ifeb_pkg::C2_TB1_F]  = evt.timebase1;
    prim_set[ifeb_pkg::C2_PIN1_F] = pin_evt[1];
    prim_set[ifeb_pkg::C2_SIM_F]  = evt.serial_module;
    prim_set[ifeb_pkg::C2_UART_F] = evt.async_serial;

    prim_next = {s_reg.primary_ctrl_2, s_reg.primary_ctrl_1, s_reg.primary_ctrl_0};
    if (ack_take) begin
      prim_next[ifeb_pkg::SRC_FLAG_POS[s_reg.irq_vec]] = 1'b0;
      prim_next[ifeb_pkg::C0_GLOBAL_EN] = 1'b0;
    end

    if (sfr_wr) begin
      unique case (sfr_sel)
        ifeb_pkg::IDX_EDGE:  s_next.edge_select = sfr_wdata & ifeb_pkg::MASK_EDGE;
        ifeb_pkg::IDX_CTRL0: prim_next[7:0]   = sfr_wdata & ifeb_pkg::MASK_CTRL0;
        ifeb_pkg::IDX_CTRL1: prim_next[15:8]  = sfr_wdata & ifeb_pkg::MASK_CTRL1;
        ifeb_pkg::IDX_CTRL2: prim_next[23:16] = sfr_wdata & ifeb_pkg::MASK_CTRL2;
        ifeb_pkg::IDX_GRP0:  s_next.group_ctrl_0 = sfr_wdata & ifeb_pkg::MASK_GRP0;
        ifeb_pkg::IDX_GRP1:  s_next.group_ctrl_1 = sfr_wdata & ifeb_pkg::MASK_GRP1;
        ifeb_pkg::IDX_GRP2:  s_next.group_ctrl_2 = sfr_wdata & ifeb_pkg::MASK_GRP2;
        default: ;
      endcase
    end

    // Sets applied last so an event is never lost to a clear
    prim_next = prim_next | prim_set;
    s_next.group_ctrl_0 = s_next.group_ctrl_0 | g0_set;
    s_next.group_ctrl_1 = s_next.group_ctrl_1 | g1_set;
    s_next.group_ctrl_2 = s_next.group_ctrl_2 | g2_set;
    {s_next.primary_ctrl_2, s_next.primary_ctrl_1, s_next.primary_ctrl_0} = prim_next;

    for (int i = 0; i < ifeb_pkg::SRC_NUM; i++) begin
      pend[i] = prim_next[ifeb_pkg::SRC_FLAG_POS[i]] &
                prim_next[ifeb_pkg::SRC_EN_POS[i]];
    end
    // Request tracks the registered flags of the same cycle
    s_next.irq_req = prim_next[ifeb_pkg::C0_GLOBAL_EN] & (|pend) & ~stack_full;
    s_next.irq_vec = first_pending(pend);

    unique case (sfr_sel)
      ifeb_pkg::IDX_EDGE:  s_next.rdata = s_reg.edge_select;
      ifeb_pkg::IDX_CTRL0: s_next.rdata = s_reg.primary_ctrl_0;
      ifeb_pkg::IDX_CTRL1: s_next.rdata = s_reg.primary_ctrl_1;
      ifeb_pkg::IDX_CTRL2: s_next.rdata = s_reg.primary_ctrl_2;
      ifeb_pkg::IDX_GRP0:  s_next.rdata = s_reg.group_ctrl_0;
      ifeb_pkg::IDX_GRP1:  s_next.rdata = s_reg.group_ctrl_1;
      ifeb_pkg::IDX_GRP2:  s_next.rdata = s_reg.group_ctrl_2;
      default:             s_next.rdata = ifeb_pkg::REG_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sfr_rdata  = s_reg.rdata;
  assign irq_req    = s_reg.irq_req;
  assign irq_vector = s_reg.irq_vec;

  ////////////////////////////////////////////////////////////////////////
  property p_first_rise;
    @(posedge clk) disable iff (sys_rst)
      (s_reg.primed && s_reg.edge_select[1:0] == 2'h1 && !s_reg.pin_prev[0] && first_ext_pin)
      |=> s_reg.primary_ctrl_0[ifeb_pkg::C0_PIN0_F];
  endproperty
  a_first_rise: assert property (p_first_rise) else $error("first pin rise not flagged");

  property p_second_off;
    @(posedge clk) disable iff (sys_rst)
      (s_reg.edge_select[3:2] == 2'h0 && !(sfr_wr && sfr_sel == ifeb_pkg::IDX_CTRL2))
      |=> !(s_reg.primary_ctrl_2[5] && !$past(s_reg.primary_ctrl_2[5]));
  endproperty
  a_second_off: assert property (p_second_off) else $error("disabled second pin flagged");

  property p_global_gate;
    @(posedge clk) disable iff (sys_rst)
      irq_req |-> s_reg.primary_ctrl_0[ifeb_pkg::C0_GLOBAL_EN];
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("request with global off");

  property p_enable_gate;
    @(posedge clk) disable iff (sys_rst)
      irq_req |-> prim_now[ifeb_pkg::SRC_EN_POS[irq_vector]];
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("request from disabled source");

  property p_service_blocks;
    @(posedge clk) disable iff (sys_rst)
      (irq_ack && irq_req) |=> !s_reg.primary_ctrl_0[ifeb_pkg::C0_GLOBAL_EN] && !irq_req;
  endproperty
  a_service_blocks: assert property (p_service_blocks) else $error("global not cleared");

  property p_members_kept;
    @(posedge clk) disable iff (sys_rst)
      (irq_ack && irq_req && irq_vector == ifeb_pkg::VEC_GRP2 && !sfr_wr)
      |=> (s_reg.group_ctrl_2 & $past(s_reg.group_ctrl_2)) == $past(s_reg.group_ctrl_2);
  endproperty
  a_members_kept: assert property (p_members_kept) else $error("member flag lost");

  property p_set_wins;
    @(posedge clk) disable iff (sys_rst)
      (sfr_wr && sfr_sel == ifeb_pkg::IDX_CTRL0 && evt.comparator)
      |=> s_reg.primary_ctrl_0[ifeb_pkg::C0_CMP_F];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

  property p_reserved_zero;
    @(posedge clk) disable iff (sys_rst)
      (s_reg.edge_select & ~ifeb_pkg::MASK_EDGE) == 8'h00 &&
      (s_reg.primary_ctrl_0 & ~ifeb_pkg::MASK_CTRL0) == 8'h00 &&
      (s_reg.group_ctrl_0 & ~ifeb_pkg::MASK_GRP0) == 8'h00 &&
      (s_reg.group_ctrl_2 & ~ifeb_pkg::MASK_GRP2) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_enables_sw_only;
    @(posedge clk) disable iff (sys_rst)
      !sfr_wr |=> $stable(s_reg.primary_ctrl_1[3:0]) && $stable(s_reg.group_ctrl_1[3:0]);
  endproperty
  a_enables_sw_only: assert property (p_enables_sw_only) else $error("enable moved");

  property p_group_feed;
    @(posedge clk) disable iff (sys_rst)
      (evt.eeprom && s_reg.group_ctrl_2[1])
      |=> s_reg.primary_ctrl_1[5] && s_reg.group_ctrl_2[ifeb_pkg::G2_EE_F];
  endproperty
  a_group_feed: assert property (p_group_feed) else $error("group 2 not raised");

endmodule
`default_nettype wire

// *** ifeb_cpu_model.sv ***
// CPU side model: takes standing requests after a chosen wait
`default_nettype none
module ifeb_cpu_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Request from the bank
  input  wire logic       irq_req,
  input  wire logic [3:0] irq_vector,
  // Control from the bench
  input  wire logic       ack_on,
  input  wire logic [3:0] ack_wait,
  // Service
  output var  logic       irq_ack,
  output var  logic [3:0] taken_vec,
  output var  logic [7:0] taken_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  initial irq_ack = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // One pulse per request; dropped at once so a second request is not acked twice
  always @(negedge clk) begin
    if (sys_rst || !ack_on || !irq_req || irq_ack) begin
      wait_cnt <= 4'h0;
      irq_ack  <= 1'b0;
    end else if (wait_cnt == ack_wait) begin
      irq_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
  always @(posedge clk) begin
    if (sys_rst) begin
      taken_cnt <= 8'h00;
      taken_vec <= 4'h0;
    end else if (irq_ack && irq_req) begin
      taken_cnt <= taken_cnt + 8'h01;
      taken_vec <= irq_vector;
    end
  end
endmodule
`default_nettype wire

// *** ifeb_tb.sv ***
// Self-checking bench for the interrupt flag and enable bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic [2:0]          sfr_sel = 3'h0;
  logic                sfr_wr = 1'b0;
  logic [7:0]          sfr_wdata = 8'h00;
  logic [7:0]          sfr_rdata;
  logic                stack_full = 1'b0;
  logic                irq_ack;
  logic                irq_req;
  logic [3:0]          irq_vector;
  logic [1:0]          pins = 2'h0;
  ifeb_pkg::ifeb_evt_s evt = '0;
  logic                ack_on = 1'b0;
  logic [3:0]          ack_wait = 4'h0;
  logic [3:0]          taken_vec;
  logic [7:0]          taken_cnt;
  int                  num_errors = 0;
  int                  samples_checked = 0;
  int                  cycles = 0;
  always #20 clk = ~clk;
  ifeb_bank dut (.clk(clk), .sys_rst(sys_rst), .sfr_sel(sfr_sel), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .stack_full(stack_full),
    .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector),
    .first_ext_pin(pins[0]), .second_ext_pin(pins[1]), .evt(evt));
  ifeb_cpu_model cpu (.clk(clk), .sys_rst(sys_rst), .irq_req(irq_req),
    .irq_vector(irq_vector), .ack_on(ack_on), .ack_wait(ack_wait), .irq_ack(irq_ack),
    .taken_vec(taken_vec), .taken_cnt(taken_cnt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    @(negedge clk);
    sfr_sel = idx;
    sfr_wr = 1'b1;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  // Read data is registered, so it is looked at one edge after the select
  task automatic rd(input logic [2:0] idx, input logic [7:0] exp, input string what);
    @(negedge clk);
    sfr_sel = idx;
    @(negedge clk);
    chk(sfr_rdata, exp, what);
  endtask
  task automatic pulse(input logic [13:0] v);
    @(negedge clk);
    evt = ifeb_pkg::ifeb_evt_s'(v);
    @(negedge clk);
    evt = '0;
    @(negedge clk);
  endtask
  task automatic take(input logic [3:0] vec);
    logic [7:0] old;
    old = taken_cnt;
    ack_on = 1'b1;
    for (int i = 0; i < 20 && taken_cnt == old; i++) @(negedge clk);
    ack_on = 1'b0;
    chk(taken_cnt, old + 8'h01, "service count");
    chk({4'h0, taken_vec}, {4'h0, vec}, "serviced vector");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_and_masks;
    logic [7:0] msk [8] = '{8'h0f, 8'h7f, 8'hff, 8'hff, 8'h33, 8'hff, 8'h33, 8'h00};
    for (int i = 0; i < 8; i++) rd(3'(i), 8'h00, "reset value");
    for (int i = 0; i < 8; i++) begin
      wr(3'(i), 8'hff);
      rd(3'(i), msk[i], "write ones");
      wr(3'(i), 8'h00);
    end
    $display("test reset_and_masks done");
  endtask
  task automatic t_sources;
    logic [2:0] idx [14] = '{3'h6, 3'h6, 3'h5, 3'h5, 3'h5, 3'h5, 3'h4, 3'h4, 3'h3, 3'h3,
                              3'h3, 3'h2, 3'h2, 3'h1};
    logic [7:0] msk [14] = '{8'h10, 8'h20, 8'h10, 8'h20, 8'h40, 8'h80, 8'h10, 8'h20,
                              8'h80, 8'h40, 8'h10, 8'h80, 8'h40, 8'h20};
    for (int k = 0; k < 14; k++) begin
      pulse(14'h1 << k);
      rd(idx[k], msk[k], "source flag");
      chk({7'h0, irq_req}, 8'h00, "disabled source raised request");
      wr(idx[k], 8'h00);
    end
    $display("test sources done");
  endtask
  task automatic t_edges;
    logic [2:0] reg_of [2] = '{3'h1, 3'h3};
    logic [7:0] bit_of [2] = '{8'h10, 8'h20};
    for (int p = 0; p < 2; p++) for (int s = 0; s < 4; s++) begin
      wr(3'h0, 8'(s << (2 * p)));
      @(negedge clk) pins[p] = 1'b1;
      rd(reg_of[p], s[0] ? bit_of[p] : 8'h00, "rising pin edge");
      wr(reg_of[p], 8'h00);
      @(negedge clk) pins[p] = 1'b0;
      rd(reg_of[p], s[1] ? bit_of[p] : 8'h00, "falling pin edge");
      wr(reg_of[p], 8'h00);
    end
    wr(3'h0, 8'h00);
    $display("test edges done");
  endtask
  task automatic t_service;
    wr(3'h2, 8'h04);
    wr(3'h1, 8'h05);
    @(negedge clk) stack_full = 1'b1;
    pulse(14'h3000);
    chk({7'h0, irq_req}, 8'h00, "request while stack full");
    @(negedge clk) stack_full = 1'b0;
    ack_wait = 4'h0;
    take(4'h1);
    rd(3'h1, 8'h04, "global enable after service");
    rd(3'h2, 8'h44, "flag latched during service");
    chk({7'h0, irq_req}, 8'h00, "request with global off");
    wr(3'h1, 8'h05);
    ack_wait = 4'h5;
    take(4'h5);
    rd(3'h2, 8'h04, "converter flag after service");
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h00);
    $display("test service done");
  endtask
  task automatic t_group;
    wr(3'h4, 8'h02);
    wr(3'h1, 8'h09);
    pulse(14'h00c0);
    chk({7'h0, irq_req}, 8'h01, "group request");
    chk({4'h0, irq_vector}, 8'h02, "group vector");
    rd(3'h1, 8'h49, "group flag set");
    take(4'h2);
    rd(3'h1, 8'h08, "group flag after service");
    rd(3'h4, 8'h32, "member flags kept");
    wr(3'h4, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h6, 8'h02);
    wr(3'h2, 8'h02);
    wr(3'h1, 8'h01);
    pulse(14'h0002);
    chk({4'h0, irq_vector}, 8'h04, "group 2 vector");
    rd(3'h2, 8'h22, "group 2 flag set");
    take(4'h4);
    rd(3'h2, 8'h02, "group 2 flag after service");
    rd(3'h6, 8'h22, "eeprom flag kept");
    wr(3'h6, 8'h00);
    wr(3'h2, 8'h00);
    $display("test group done");
  endtask
  task automatic t_set_wins;
    @(negedge clk);
    sfr_sel = 3'h1;
    sfr_wr = 1'b1;
    sfr_wdata = 8'h00;
    evt = ifeb_pkg::ifeb_evt_s'(14'h2000);
    @(negedge clk);
    sfr_wr = 1'b0;
    evt = '0;
    rd(3'h1, 8'h20, "set against clear");
    wr(3'h1, 8'h00);
    $display("test set_wins done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Whole run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("MISMATCH at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    t_reset_and_masks();
    t_sources();
    t_edges();
    t_service();
    t_group();
    t_set_wins();
    tally_and_finish();
  end
endmodule
`default_nettype wire
